//--- hw/gpfs_pkg.sv
// package: register map, field positions and reset values of the port block
package gpfs_pkg;

  // ********************************
  // register byte offsets
  // ********************************
  localparam logic [7:0] OFF_P6_DATA  = 8'h00;
  localparam logic [7:0] OFF_P6_DIR   = 8'h04;
  localparam logic [7:0] OFF_P8_DATA  = 8'h08;
  localparam logic [7:0] OFF_P8_DIR   = 8'h0c;
  localparam logic [7:0] OFF_P9_DATA  = 8'h10;
  localparam logic [7:0] OFF_P9_DIR   = 8'h14;
  localparam logic [7:0] OFF_P9_MODE  = 8'h18;
  localparam logic [7:0] OFF_AN_MODE  = 8'h1c;
  localparam logic [7:0] OFF_CNV_MODE = 8'h20;
  localparam logic [7:0] OFF_AN_PORT  = 8'h24;

  // ********************************
  // field positions
  // ********************************
  localparam int MODE_EXT_INTERRUPT_FOUR_SELECT_BIT = 2;
  localparam int MODE_RSV3_BIT = 3;
  localparam int AN_EXT_INTERRUPT_ZERO_SELECT_BIT   = 0;
  localparam int AN_EXT_INTERRUPT_ONE_SELECT_BIT   = 1;
  localparam int AN_EXT_INTERRUPT_THREE_SELECT_BIT   = 2;

  // ********************************
  // channel codes and reset values
  // ********************************
  localparam logic [3:0] CH_AN0 = 4'h4;
  localparam logic [3:0] CH_AN1 = 4'h5;
  localparam logic [3:0] CH_AN2 = 4'h6;

  localparam logic [7:0] RST_DATA  = 8'h00;
  localparam logic [7:0] RST_DIR   = 8'h00;
  localparam logic [3:0] RST_NIB   = 4'h0;
  localparam logic [7:0] READ_ONES = 8'hff;
  localparam logic [3:0] HI_ONES   = 4'hf;

  // apb answer phases
  typedef enum logic [1:0] {
    GPFS_IDLE   = 2'b00,
    GPFS_ACCESS = 2'b01
  } gpfs_bus_t;

endpackage : gpfs_pkg

//--- hw/gpfs_mux_if.sv
// interface: analog port function selection between top and pin mux
`timescale 1ns/100ps
`default_nettype none
interface gpfs_mux_if;
  logic [2:0] irq_sel;
  logic [3:0] chan;
  logic [2:0] pin;
  logic [2:0] an_en;
  logic [2:0] irq;
  logic [2:0] gp_rd;

  modport ctrl (output irq_sel, chan, pin, input an_en, irq, gp_rd);
  modport mux  (input irq_sel, chan, pin, output an_en, irq, gp_rd);
endinterface : gpfs_mux_if
`default_nettype wire

//--- hw/gpfs_pin_mux.sv
// module: function selection for the three shared analog port pins
`timescale 1ns/100ps
`default_nettype none
module gpfs_pin_mux (
  gpfs_mux_if.mux m
);
  import gpfs_pkg::*;

  // ********************************
  // per pin decode
  // ********************************
  localparam logic [3:0] CODE [3] = '{CH_AN2, CH_AN1, CH_AN0};

  genvar g;
  generate
    for (g = 0; g < 3; g++) begin : g_pin
      // interrupt select wins, then channel match, else plain input
      assign m.irq[g]   = m.irq_sel[g] & m.pin[g];
      assign m.an_en[g] = ~m.irq_sel[g] &
                          (m.chan == CODE[2-g]);
      assign m.gp_rd[g] = ~m.irq_sel[g] & ~m.an_en[g] & m.pin[g];
    end
  endgenerate

endmodule : gpfs_pin_mux
`default_nettype wire

//--- hw/gpfs_top.sv
// module: apb register file and pin logic for ports 6, 8, 9 and analog port
//
// The APB register port and the register addresses were left to the implementer.
`timescale 1ns/100ps
`default_nettype none

module gpfs_top (
  // clock and reset
  input  wire logic       clk_i,
  input  wire logic       sys_rst_i,
  // apb slave
  input  wire logic       psel_i,
  input  wire logic       penable_i,
  input  wire logic       pwrite_i,
  input  wire logic [7:0] paddr_i,
  input  wire logic [31:0] pwdata_i,
  output logic [31:0]     prdata_o,
  output logic            pready_o,
  output logic            pslverr_o,
  // port 6 pins
  input  wire logic [7:0] p6_pin_i,
  output logic [7:0]      p6_out_o,
  output logic [7:0]      p6_oe_o,
  // port 8 pins
  input  wire logic [7:0] p8_pin_i,
  output logic [7:0]      p8_out_o,
  output logic [7:0]      p8_oe_o,
  // port 9 pins
  input  wire logic [3:0] p9_pin_i,
  output logic [3:0]      p9_out_o,
  output logic [3:0]      p9_oe_o,
  // analog port pins 2 to 0
  input  wire logic [2:0] pb_pin_i,
  output logic [2:0]      an_en_o,
  // external interrupt inputs, level of the pin while selected
  output logic            ext_interrupt_zero_select_o,
  output logic            ext_interrupt_one_select_o,
  output logic            ext_interrupt_three_select_o,
  output logic            ext_interrupt_four_select_o
);
  import gpfs_pkg::*;

  // ********************************
  // storage
  // ********************************
  logic [7:0]  p6_data_reg;
  logic [7:0]  p6_dir_reg;
  logic [7:0]  p8_data_reg;
  logic [7:0]  p8_dir_reg;
  logic [3:0]  p9_data_reg;
  logic [3:0]  p9_dir_reg;
  logic [3:0]  p9_mode_reg;
  logic [2:0]  an_mode_reg;
  logic [3:0]  cnv_chan_reg;
  gpfs_bus_t   bus_reg;
  logic [31:0] rdata_next;
  logic        hit_next;
  logic        wr_en;
  logic        setup;
  logic [7:0]  p6_rd;
  logic [7:0]  p8_rd;
  logic [3:0]  p9_rd;
  logic [3:0]  p9_gpio;

  gpfs_mux_if mux_if ();

  gpfs_pin_mux u_pin_mux (
    .m (mux_if.mux)
  );

  // ********************************
  // address decode
  // ********************************
  function automatic logic is_at(input logic [7:0] a,
                                 input logic [7:0] off);
    is_at = (a == off);
  endfunction : is_at

  function automatic logic is_mapped(input logic [7:0] a);
    is_mapped = is_at(a, OFF_P6_DATA) | is_at(a, OFF_P6_DIR) |
                is_at(a, OFF_P8_DATA) | is_at(a, OFF_P8_DIR) |
                is_at(a, OFF_P9_DATA) | is_at(a, OFF_P9_DIR) |
                is_at(a, OFF_P9_MODE) | is_at(a, OFF_AN_MODE) |
                is_at(a, OFF_CNV_MODE) | is_at(a, OFF_AN_PORT);
  endfunction : is_mapped

  assign setup = psel_i & ~penable_i;
  assign wr_en = psel_i & penable_i & pready_o & pwrite_i & pslverr_o == 1'b0;

  // ********************************
  // apb handshake
  // ********************************
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      bus_reg   <= GPFS_IDLE;
      pready_o  <= 1'b0;
      pslverr_o <= 1'b0;
      prdata_o  <= 32'h0000_0000;
    end else begin
      case (bus_reg)
        GPFS_IDLE: begin
          if (setup) begin
            bus_reg   <= GPFS_ACCESS;
            pready_o  <= 1'b1;
            pslverr_o <= ~hit_next;
            prdata_o  <= pwrite_i ? 32'h0000_0000 : rdata_next;
          end
        end
        GPFS_ACCESS: begin
          bus_reg   <= GPFS_IDLE;
          pready_o  <= 1'b0;
          pslverr_o <= 1'b0;
          prdata_o  <= 32'h0000_0000;
        end
        default: begin
          bus_reg  <= GPFS_IDLE;
          pready_o <= 1'b0;
        end
      endcase
    end
  end

  // ********************************
  // pin read values
  // ********************************
  genvar g;
  generate
    for (g = 0; g < 8; g++) begin : g_rd8
      // output pins read the latch, input pins the pin level
      assign p6_rd[g] = p6_dir_reg[g] ? p6_data_reg[g]
                                      : p6_pin_i[g];
      assign p8_rd[g] = p8_dir_reg[g] ? p8_data_reg[g]
                                      : p8_pin_i[g];
    end
    for (g = 0; g < 4; g++) begin : g_rd9
      assign p9_gpio[g] = (g == MODE_EXT_INTERRUPT_FOUR_SELECT_BIT) ?
                          ~p9_mode_reg[MODE_EXT_INTERRUPT_FOUR_SELECT_BIT] : 1'b1;
      assign p9_rd[g] = (p9_dir_reg[g] & p9_gpio[g]) ? p9_data_reg[g]
                                                     : p9_pin_i[g];
    end
  endgenerate

  // ********************************
  // read multiplexer
  // ********************************
  always_comb begin
    rdata_next = 32'h0000_0000;
    hit_next   = is_mapped(paddr_i);
    case (paddr_i)
      OFF_P6_DATA:  rdata_next[7:0] = p6_rd;
      OFF_P6_DIR:   rdata_next[7:0] = READ_ONES;
      OFF_P8_DATA:  rdata_next[7:0] = p8_rd;
      OFF_P8_DIR:   rdata_next[7:0] = READ_ONES;
      OFF_P9_DATA:  rdata_next[3:0] = p9_rd;
      OFF_P9_DIR:   rdata_next[7:0] = READ_ONES;
      OFF_P9_MODE:  rdata_next[7:0] = {HI_ONES, p9_mode_reg};
      OFF_AN_MODE:  rdata_next[2:0] = an_mode_reg;
      OFF_CNV_MODE: rdata_next[3:0] = cnv_chan_reg;
      OFF_AN_PORT:  rdata_next[2:0] = mux_if.gp_rd;
      default:      rdata_next = 32'h0000_0000;
    endcase
  end

  // ********************************
  // data latches
  // ********************************
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      p6_data_reg <= RST_DATA;
      p8_data_reg <= RST_DATA;
      p9_data_reg <= RST_NIB;
    end else if (wr_en) begin
      if (is_at(paddr_i, OFF_P6_DATA)) begin
        p6_data_reg <= pwdata_i[7:0];
      end
      if (is_at(paddr_i, OFF_P8_DATA)) begin
        p8_data_reg <= pwdata_i[7:0];
      end
      if (is_at(paddr_i, OFF_P9_DATA)) begin
        p9_data_reg <= pwdata_i[3:0];
      end
    end
  end

  // ********************************
  // direction settings, kept inside
  // ********************************
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      p6_dir_reg <= RST_DIR;
      p8_dir_reg <= RST_DIR;
      p9_dir_reg <= RST_NIB;
    end else if (wr_en) begin
      if (is_at(paddr_i, OFF_P6_DIR)) begin
        p6_dir_reg <= pwdata_i[7:0];
      end
      if (is_at(paddr_i, OFF_P8_DIR)) begin
        p8_dir_reg <= pwdata_i[7:0];
      end
      if (is_at(paddr_i, OFF_P9_DIR)) begin
        p9_dir_reg <= pwdata_i[3:0];
      end
    end
  end

  // ********************************
  // function select registers
  // ********************************
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      p9_mode_reg  <= RST_NIB;
      an_mode_reg  <= 3'h0;
      cnv_chan_reg <= RST_NIB;
    end else if (wr_en) begin
      if (is_at(paddr_i, OFF_P9_MODE)) begin
        p9_mode_reg <= pwdata_i[3:0];
      end
      if (is_at(paddr_i, OFF_AN_MODE)) begin
        an_mode_reg <= pwdata_i[2:0];
      end
      if (is_at(paddr_i, OFF_CNV_MODE)) begin
        cnv_chan_reg <= pwdata_i[3:0];
      end
    end
  end

  // ********************************
  // pin mux hookup
  // ********************************
  assign mux_if.irq_sel = {an_mode_reg[AN_EXT_INTERRUPT_THREE_SELECT_BIT],
                           an_mode_reg[AN_EXT_INTERRUPT_ONE_SELECT_BIT],
                           an_mode_reg[AN_EXT_INTERRUPT_ZERO_SELECT_BIT]};
  assign mux_if.chan    = cnv_chan_reg;
  assign mux_if.pin     = pb_pin_i;

  // ********************************
  // pin drivers
  // ********************************
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      p6_out_o <= RST_DATA;
      p6_oe_o  <= RST_DIR;
      p8_out_o <= RST_DATA;
      p8_oe_o  <= RST_DIR;
      p9_out_o <= RST_NIB;
      p9_oe_o  <= RST_NIB;
    end else begin
      p6_out_o <= p6_data_reg;
      p6_oe_o  <= p6_dir_reg;
      p8_out_o <= p8_data_reg;
      p8_oe_o  <= p8_dir_reg;
      p9_out_o <= p9_data_reg & p9_gpio;
      p9_oe_o  <= p9_dir_reg & p9_gpio;
    end
  end

  // ********************************
  // interrupt and analog outputs
  // ********************************
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      an_en_o <= 3'h0;
      ext_interrupt_zero_select_o  <= 1'b0;
      ext_interrupt_one_select_o  <= 1'b0;
      ext_interrupt_three_select_o  <= 1'b0;
      ext_interrupt_four_select_o  <= 1'b0;
    end else begin
      an_en_o <= mux_if.an_en;
      ext_interrupt_zero_select_o  <= mux_if.irq[0];
      ext_interrupt_one_select_o  <= mux_if.irq[1];
      ext_interrupt_three_select_o  <= mux_if.irq[2];
      ext_interrupt_four_select_o  <= p9_mode_reg[MODE_EXT_INTERRUPT_FOUR_SELECT_BIT] &
                 p9_pin_i[MODE_EXT_INTERRUPT_FOUR_SELECT_BIT];
    end
  end

  // ********************************
  // checks
  // ********************************
  AST_PORT_READ_VALUE: assert property (
    @(posedge clk_i) disable iff (sys_rst_i)
    (setup && !pwrite_i && paddr_i == OFF_P6_DATA) |=>
      prdata_o[7:0] == (($past(p6_data_reg) & $past(p6_dir_reg)) |
                        ($past(p6_pin_i) & ~$past(p6_dir_reg))))
    else $error("port 6 read value wrong");

  AST_INPUT_PIN_READ: assert property (
    @(posedge clk_i) disable iff (sys_rst_i)
    (setup && !pwrite_i && paddr_i == OFF_P8_DATA && p8_dir_reg == 8'h00)
      |=> prdata_o[7:0] == $past(p8_pin_i))
    else $error("port 8 input read wrong");

  AST_DIR_DRIVES_OE: assert property (
    @(posedge clk_i) disable iff (sys_rst_i)
    ##1 p6_oe_o == $past(p6_dir_reg) && p8_oe_o == $past(p8_dir_reg))
    else $error("enable does not follow direction");

  AST_DIR_READS_ONES: assert property (
    @(posedge clk_i) disable iff (sys_rst_i)
    (setup && !pwrite_i && (paddr_i == OFF_P6_DIR ||
     paddr_i == OFF_P8_DIR || paddr_i == OFF_P9_DIR)) |=>
      prdata_o == 32'h0000_00ff && pready_o)
    else $error("direction read not all ones");

  AST_EXT_INTERRUPT_FOUR_SELECT_OWNS_PIN: assert property (
    @(posedge clk_i) disable iff (sys_rst_i)
    p9_mode_reg[MODE_EXT_INTERRUPT_FOUR_SELECT_BIT] |=> !p9_oe_o[MODE_EXT_INTERRUPT_FOUR_SELECT_BIT])
    else $error("pin 2 driven while interrupt owns it");

  AST_RESET_CLEARS: assert property (
    @(posedge clk_i)
    $fell(sys_rst_i) |-> p6_data_reg == 8'h00 && p8_dir_reg == 8'h00 &&
      p6_oe_o == 8'h00 && p8_out_o == 8'h00)
    else $error("port state not cleared by reset");

  AST_HIGH_NIBBLE_ONES: assert property (
    @(posedge clk_i) disable iff (sys_rst_i)
    (setup && !pwrite_i && paddr_i == OFF_P9_MODE) |=>
      prdata_o[7:4] == 4'hf && prdata_o[3:0] == $past(p9_mode_reg))
    else $error("port 9 mode read wrong");

  AST_EXT_INTERRUPT_FOUR_SELECT_FOLLOWS_PIN: assert property (
    @(posedge clk_i) disable iff (sys_rst_i)
    (p9_mode_reg[MODE_EXT_INTERRUPT_FOUR_SELECT_BIT] && p9_pin_i[MODE_EXT_INTERRUPT_FOUR_SELECT_BIT]) |=> ext_interrupt_four_select_o)
    else $error("interrupt four not routed");

  AST_DIR_KEPT: assert property (
    @(posedge clk_i) disable iff (sys_rst_i)
    (setup && !pwrite_i && paddr_i == OFF_P6_DIR) |=>
      ##1 p6_oe_o == $past(p6_oe_o))
    else $error("direction lost after read");

  AST_AN2_SELECT: assert property (
    @(posedge clk_i) disable iff (sys_rst_i)
    (!an_mode_reg[AN_EXT_INTERRUPT_THREE_SELECT_BIT] && cnv_chan_reg == CH_AN2) |=>
      an_en_o[2] && !ext_interrupt_three_select_o)
    else $error("pin two analog select wrong");

  AST_AN1_SELECT: assert property (
    @(posedge clk_i) disable iff (sys_rst_i)
    (!an_mode_reg[AN_EXT_INTERRUPT_ONE_SELECT_BIT] && cnv_chan_reg == CH_AN1) |=>
      an_en_o[1] && !ext_interrupt_one_select_o)
    else $error("pin one analog select wrong");

  AST_AN0_EXCL: assert property (
    @(posedge clk_i) disable iff (sys_rst_i)
    an_mode_reg[AN_EXT_INTERRUPT_ZERO_SELECT_BIT] |=>
      !an_en_o[0] && ext_interrupt_zero_select_o == $past(pb_pin_i[0]))
    else $error("pin zero function conflict");

endmodule : gpfs_top
`default_nettype wire

//--- verification/gpfs_pin_model.sv
// partner: external circuitry on the general-purpose pins
`timescale 1ns/100ps
`default_nettype none
module gpfs_pin_model (
  // device side of the pins
  input  wire logic [7:0] p6_out_i,
  input  wire logic [7:0] p6_oe_i,
  input  wire logic [7:0] p8_out_i,
  input  wire logic [7:0] p8_oe_i,
  input  wire logic [3:0] p9_out_i,
  input  wire logic [3:0] p9_oe_i,
  // levels driven by the outside circuitry
  input  wire logic [7:0] p6_ext_i,
  input  wire logic [7:0] p8_ext_i,
  input  wire logic [3:0] p9_ext_i,
  // resolved pin levels
  output logic      [7:0] p6_pin_o,
  output logic      [7:0] p8_pin_o,
  output logic      [3:0] p9_pin_o
);
  // outside drives only where the device leaves the pin
  assign p6_pin_o = (p6_oe_i & p6_out_i) | (~p6_oe_i & p6_ext_i);
  assign p8_pin_o = (p8_oe_i & p8_out_i) | (~p8_oe_i & p8_ext_i);
  assign p9_pin_o = (p9_oe_i & p9_out_i) | (~p9_oe_i & p9_ext_i);
endmodule : gpfs_pin_model
`default_nettype wire

//--- verification/gpfs_top_test.sv
// testbench: register and pin scenarios for the port block
`timescale 1ns/100ps
`default_nettype none
module gpfs_top_test;
  import gpfs_pkg::*;
  // ********************************
  // signals
  // ********************************
  logic        clk_i     = 1'b0;
  logic        sys_rst_i = 1'b1;
  logic        psel_i    = 1'b0;
  logic        penable_i = 1'b0;
  logic        pwrite_i  = 1'b0;
  logic [7:0]  paddr_i   = 8'h00;
  logic [31:0] pwdata_i  = 32'h0;
  logic [7:0]  p6_ext    = 8'h3c;
  logic [7:0]  p8_ext    = 8'h3c;
  logic [3:0]  p9_ext    = 4'h0;
  logic [2:0]  pb_pin_i  = 3'b111;
  logic [31:0] prdata_o;
  logic        pready_o;
  logic        pslverr_o;
  logic [7:0]  p6_pin, p6_out_o, p6_oe_o, p8_pin, p8_out_o, p8_oe_o;
  logic [3:0]  p9_pin, p9_out_o, p9_oe_o;
  logic [2:0]  an_en_o;
  logic        ext_interrupt_zero_select_o, ext_interrupt_one_select_o, ext_interrupt_three_select_o, ext_interrupt_four_select_o;
  logic [31:0] rd;
  logic        err;
  int          fails       = 0;
  int          comparisons = 0;

  always #5 clk_i = ~clk_i;

  gpfs_top gpfs_top_i (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
    .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i),
    .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
    .pready_o(pready_o), .pslverr_o(pslverr_o), .p6_pin_i(p6_pin),
    .p6_out_o(p6_out_o), .p6_oe_o(p6_oe_o), .p8_pin_i(p8_pin),
    .p8_out_o(p8_out_o), .p8_oe_o(p8_oe_o), .p9_pin_i(p9_pin),
    .p9_out_o(p9_out_o), .p9_oe_o(p9_oe_o), .pb_pin_i(pb_pin_i),
    .an_en_o(an_en_o), .ext_interrupt_zero_select_o(ext_interrupt_zero_select_o), .ext_interrupt_one_select_o(ext_interrupt_one_select_o),
    .ext_interrupt_three_select_o(ext_interrupt_three_select_o), .ext_interrupt_four_select_o(ext_interrupt_four_select_o));

  gpfs_pin_model gpfs_pin_model_i (.p6_out_i(p6_out_o), .p6_oe_i(p6_oe_o),
    .p8_out_i(p8_out_o), .p8_oe_i(p8_oe_o), .p9_out_i(p9_out_o),
    .p9_oe_i(p9_oe_o), .p6_ext_i(p6_ext), .p8_ext_i(p8_ext),
    .p9_ext_i(p9_ext), .p6_pin_o(p6_pin), .p8_pin_o(p8_pin),
    .p9_pin_o(p9_pin));

  // ********************************
  // tasks
  // ********************************
  task automatic wrap_up;
    $display("counts: comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : wrap_up

  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH at %0t: word %h expected %h", $time, got, exp);
    end
  endtask : chk_word

  task automatic chk_pins(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH at %0t: pins %h expected %h", $time, got, exp);
    end
  endtask : chk_pins

  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    psel_i    <= 1'b1;
    penable_i <= 1'b0;
    pwrite_i  <= w;
    paddr_i   <= a;
    pwdata_i  <= d;
    @(posedge clk_i);
    penable_i <= 1'b1;
    @(posedge clk_i);
    while (pready_o !== 1'b1 && n < 50) begin
      n++;
      @(posedge clk_i);
    end
    if (n >= 50) begin
      fails++;
      $display("MISMATCH at %0t: no ready", $time);
    end
    rd = prdata_o;
    err = pslverr_o;
    psel_i    <= 1'b0;
    penable_i <= 1'b0;
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr

  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk_word(rd, exp);
  endtask : rdc

  task automatic settle;
    repeat (3) @(posedge clk_i);
  endtask : settle

  // ********************************
  // watchdog
  // ********************************
  initial begin
    #100000;
    fails++;
    $display("MISMATCH at %0t: watchdog", $time);
    wrap_up();
  end

  // ********************************
  // tests
  // ********************************
  initial begin
    logic [7:0] da;
    logic [7:0] ca;
    repeat (5) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    settle();
    chk_pins(p6_oe_o | p8_oe_o, 8'h00);
    rdc(OFF_P6_DIR, 32'h000000ff);
    rdc(OFF_P8_DIR, 32'h000000ff);
    rdc(OFF_P9_DIR, 32'h000000ff);
    rdc(OFF_P9_MODE, 32'h000000f0);
    rdc(OFF_P6_DATA, 32'h3c);
    rdc(OFF_P8_DATA, 32'h3c);
    wr(OFF_P6_DIR, 32'hff);
    wr(OFF_P8_DIR, 32'hff);
    rdc(OFF_P6_DATA, 32'h0);
    rdc(OFF_P8_DATA, 32'h0);
    $display("test reset done");
    for (int k = 0; k < 2; k++) begin
      da = k ? OFF_P8_DATA : OFF_P6_DATA;
      ca = k ? OFF_P8_DIR : OFF_P6_DIR;
      wr(da, 32'ha5);
      wr(ca, 32'h0f);
      settle();
      chk_pins(k ? p8_oe_o : p6_oe_o, 8'h0f);
      chk_pins(k ? (p8_out_o & p8_oe_o)
                 : (p6_out_o & p6_oe_o), 8'h05);
      rdc(da, 32'h35);
      rdc(ca, 32'hff);
      wr(ca, 32'hf0);
      settle();
      rdc(da, 32'hac);
    end
    $display("test ports 6 and 8 done");
    p9_ext <= 4'h5;
    wr(OFF_P9_DIR, 32'h0f);
    wr(OFF_P9_DATA, 32'h0a);
    settle();
    chk_pins({4'h0, p9_oe_o}, 8'h0f);
    chk_pins({4'h0, p9_out_o}, 8'h0a);
    apb(1'b0, OFF_P9_DATA, 32'h0);
    chk_word({28'h0, rd[3:0]}, 32'ha);
    wr(OFF_P9_MODE, 32'h04);
    settle();
    chk_pins({4'h0, p9_oe_o}, 8'h0b);
    chk_pins({7'h0, ext_interrupt_four_select_o}, 8'h01);
    apb(1'b0, OFF_P9_DATA, 32'h0);
    chk_word({28'h0, rd[3:0]}, 32'he);
    rdc(OFF_P9_MODE, 32'hf4);
    p9_ext <= 4'h1;
    settle();
    chk_pins({7'h0, ext_interrupt_four_select_o}, 8'h00);
    wr(OFF_P9_MODE, 32'h00);
    p9_ext <= 4'h5;
    settle();
    chk_pins({7'h0, ext_interrupt_four_select_o}, 8'h00);
    chk_pins({4'h0, p9_oe_o}, 8'h0f);
    $display("test port 9 done");
    for (int k = 0; k < 3; k++) begin
      wr(OFF_AN_MODE, 32'h0);
      wr(OFF_CNV_MODE, {28'h0, CH_AN0 + 4'(k)});
      settle();
      chk_pins({5'h0, an_en_o}, 8'h01 << k);
      chk_pins({5'h0, ext_interrupt_three_select_o, ext_interrupt_one_select_o, ext_interrupt_zero_select_o}, 8'h00);
      rdc(OFF_AN_PORT, 32'h7 & ~(32'h1 << k));
      wr(OFF_AN_MODE, 32'h1 << k);
      settle();
      chk_pins({5'h0, an_en_o}, 8'h00);
      chk_pins({5'h0, ext_interrupt_three_select_o, ext_interrupt_one_select_o, ext_interrupt_zero_select_o}, 8'h01 << k);
    end
    wr(OFF_AN_MODE, 32'h0);
    wr(OFF_CNV_MODE, 32'h0);
    pb_pin_i <= 3'b101;
    settle();
    chk_pins({5'h0, an_en_o}, 8'h00);
    rdc(OFF_AN_PORT, 32'h5);
    $display("test analog port done");
    sys_rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    settle();
    chk_pins(p8_oe_o | p8_out_o, 8'h00);
    rdc(OFF_P8_DATA, 32'h3c);
    wr(OFF_P8_DIR, 32'hff);
    rdc(OFF_P8_DATA, 32'h0);
    $display("test mid reset done");
    wr(8'h28, 32'hff);
    chk_pins({7'h0, err}, 8'h01);
    apb(1'b0, 8'h28, 32'h0);
    chk_word(rd, 32'h0);
    chk_pins({7'h0, err}, 8'h01);
    $display("test unmapped done");
    wrap_up();
  end
endmodule : gpfs_top_test
`default_nettype wire
